/* dv/wake_event_status_enable_tb.sv */
// self-checking bench of the wake event block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
$display("ERROR %s expected %h seen %h", nm, e, g); end end
module wake_event_status_enable_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ps;
   logic wake_out_n, wake_seen, ack = 1, ack_n = 0, mpor = 0, hrst = 0, srst = 0, exp_n;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [7:0] gc = 0, ge = 0, gce = 0, gee = 0, pws = 0, sc = 0, se = 0, sp = 8'h01, en, m;
   logic [7:1] pev = 0;
   int num_errors = 0, comparisons = 0, seed = 26964, cyc = 0, i;
   wesen_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gpio_group_c_wake(gc), .gpio_group_e_wake(ge),
      .printer_ack_n(ack_n), .serial_port2_event(pev[1]), .serial_port1_event(pev[2]),
      .floppy_ctrl_event(pev[3]), .mouse_ctrl_event(pev[4]), .keyboard_ctrl_event(pev[5]),
      .watchdog_event(pev[6]), .two_wire_ctrl_event(pev[7]), .main_por(mpor),
      .hard_reset(hrst), .soft_reset(srst), .peripheral_wake_status(pws),
      .gpio_group_c_enable(gce), .gpio_group_e_enable(gee), .wake_out_n(wake_out_n));
   wesen_host_rx host (.pclk(pclk), .presetn(presetn), .wake_out_n(wake_out_n), .ack(ack),
      .wake_seen(wake_seen));
   initial begin
      forever #5 pclk = ~pclk;
   end
   task automatic print_verdict;
      if (num_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         print_verdict;
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      ps = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(nm, {24'h00_0000, e}, rd)
   endtask
   initial begin
      step(3);
      presetn <= 1'b1;
      step(1);
      rdchk(12'h01C, 8'h00, "gpio_c_sts");
      rdchk(12'h024, 8'h01, "periph_sts");
      rdchk(12'h028, 8'h00, "periph_en");
      rdchk(12'h200, 8'h00, "gpio_e_sts");
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      `CHK("unmapped_err", 1'b1, ps)
      for (i = 0; i < 6; i++) begin
         gc <= 8'($random(seed));
         ge <= 8'($random(seed));
         pev <= 7'($random(seed));
         step(1);
         sc = sc | gc;
         se = se | ge;
         sp = sp | {pev, 1'b0};
         gc <= 8'h00;
         ge <= 8'h00;
         pev <= 7'h00;
         step(4);
         rdchk(12'h01C, sc, "gpio_c_sts");
         rdchk(12'h200, se, "gpio_e_sts");
         rdchk(12'h024, sp, "periph_sts");
         m = 8'($random(seed));
         apb(1'b1, 12'h01C, {24'h00_0000, m});
         sc = sc & ~m;
         rdchk(12'h01C, sc, "gpio_c_w1c");
         apb(1'b1, 12'h200, {24'h00_0000, m});
         se = se & ~m;
         rdchk(12'h200, se, "gpio_e_w1c");
      end
      gc <= 8'h01;
      step(4);
      apb(1'b1, 12'h01C, 32'h0000_00FF);
      rdchk(12'h01C, 8'h01, "set_wins");
      gc <= 8'h00;
      step(4);
      apb(1'b1, 12'h01C, 32'h0000_00FF);
      sc = 8'h00;
      apb(1'b1, 12'h024, 32'h0000_00FF);
      rdchk(12'h024, 8'h01, "pp_idle_high");
      apb(1'b1, 12'h008, 32'h0000_0002);
      step(4);
      apb(1'b1, 12'h024, 32'h0000_00FF);
      rdchk(12'h024, 8'h00, "pp_ack_low");
      ack_n <= 1'b1;
      step(4);
      rdchk(12'h024, 8'h01, "pp_ack_high");
      ack_n <= 1'b0;
      pev <= 7'h55;
      step(1);
      pev <= 7'h00;
      apb(1'b1, 12'h028, 32'h0000_005A);
      for (i = 0; i < 3; i++) begin
         step(4);
         apb(1'b1, 12'h024, 32'h0000_0001);
         {mpor, hrst, srst} <= 3'b100 >> i;
         step(1);
         {mpor, hrst, srst} <= 3'b000;
         step(5);
         rdchk(12'h024, 8'hAB, "reset_bit0");
         rdchk(12'h028, 8'h5A, "en_kept");
      end
      for (i = 0; i < 12; i++) begin
         en = 8'($random(seed));
         m = 8'($random(seed));
         ack <= 1'b1;
         apb(1'b1, 12'h028, {24'h00_0000, en});
         apb(1'b1, 12'h008, {30'h0, 1'b1, m[0]});
         pws <= 8'($random(seed));
         gce <= 8'($random(seed));
         gee <= 8'($random(seed));
         step(3);
         ack <= 1'b0;
         step(3);
         exp_n = !(m[0] && |((pws & en) | (sc & gce) | (se & gee)));
         `CHK("wake_out_n", exp_n, wake_out_n)
         `CHK("host_seen", ~exp_n, wake_seen)
         rdchk(12'h028, en, "periph_en");
      end
      print_verdict;
   end
endmodule

/* dv/wesen_host_rx.sv */
// host-side wake input model
`timescale 1ns/10ps
module wesen_host_rx (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wake_out_n,
   input wire logic ack,
   output logic wake_seen
);
   // holds a seen wake level until the host acknowledges it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_seen <= 1'b0;
      end else if (ack) begin
         wake_seen <= 1'b0;
      end else if (!wake_out_n) begin
         wake_seen <= 1'b1;
      end
   end
endmodule

/* rtl/wesen_map.svh */
// register map, reset values and field positions of the wake event block
`ifndef WESEN_MAP_SVH
`define WESEN_MAP_SVH
`define WESEN_IDX_GLOBAL_CTRL 8'h02
`define WESEN_IDX_GPIO_C 8'h07
`define WESEN_IDX_PERIPH_STS 8'h09
`define WESEN_IDX_PERIPH_EN 8'h0A
`define WESEN_IDX_GPIO_E 8'h80
`define WESEN_RST_GPIO_C 8'h00
`define WESEN_RST_GPIO_E 8'h00
`define WESEN_RST_PERIPH_STS 8'h01
`define WESEN_RST_PERIPH_EN 8'h00
`define WESEN_RST_GLOBAL_CTRL 8'h00
`define WESEN_BIT_GLOBAL_EN 0
`define WESEN_BIT_PP_ACTIVE 1
`define WESEN_BIT_PP_EVENT 0
`define WESEN_ADDR_W 12
`endif

/* rtl/wesen_pkg.sv */
// types shared by the wake event block
package wesen_pkg;
   typedef logic [7:0] wesen_byte_t;
   typedef enum logic [5:0] {
      WESEN_SEL_NONE = 6'b00_0001,
      WESEN_SEL_GPIO_C = 6'b00_0010,
      WESEN_SEL_PERIPH_STS = 6'b00_0100,
      WESEN_SEL_PERIPH_EN = 6'b00_1000,
      WESEN_SEL_GPIO_E = 6'b01_0000,
      WESEN_SEL_CTRL = 6'b10_0000
   } wesen_sel_t;
endpackage

/* rtl/wesen_sync.sv */
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module wesen_sync #(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   always_comb begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule

/* rtl/wesen_top.sv */
// wake event status and enable registers with apb access and wake output
`timescale 1ns/10ps
`include "wesen_map.svh"

// Function
// - each gpio wake status bit sets on its source event regardless of any enable.
// - writing 1 to a status bit clears it and writing 0 leaves it alone.
// - wake status registers clear only on standby power-on reset, not on other resets.
// - gpio group c status bits 0..7 are gpio 3.0, 3.1, 3.2, 3.3, 4.1, 4.3, 6.0, 6.1.
// - gpio group e status at index 80 has bits 0..7 as gpio 5.0 to 5.7.
// - status 09: parallel, serial2, serial1, floppy, mouse, keyboard, watchdog, two-wire.
// - a peripheral status bit sets on its event regardless of any enable.
// - peripheral status is 0x01 after standby power-on reset.
// - bit 0 of status 09 is set by any reset; other bits survive all but standby reset.
// - parallel source is 1 while the port is inactive, else it follows acknowledge.
// - wake output goes low when a source is enabled and set and global enable is on.
// - a disabled source still records status but never drives the wake output.
// - enable 0A maps kbc pin a, kbc pin b, ring 1, keyboard, mouse, key, tach, ring 2.
// - peripheral wake enable clears only on standby power-on reset.
// - global wake enable off keeps the wake output inactive.
module wesen_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`WESEN_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] gpio_group_c_wake,
   input wire logic [7:0] gpio_group_e_wake,
   input wire logic printer_ack_n,
   input wire logic serial_port2_event,
   input wire logic serial_port1_event,
   input wire logic floppy_ctrl_event,
   input wire logic mouse_ctrl_event,
   input wire logic keyboard_ctrl_event,
   input wire logic watchdog_event,
   input wire logic two_wire_ctrl_event,
   input wire logic main_por,
   input wire logic hard_reset,
   input wire logic soft_reset,
   input wire logic [7:0] peripheral_wake_status,
   input wire logic [7:0] gpio_group_c_enable,
   input wire logic [7:0] gpio_group_e_enable,
   output logic wake_out_n
);
   localparam int SYNC_W = 27;

   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_in;
   wesen_pkg::wesen_byte_t src_c;
   wesen_pkg::wesen_byte_t src_e;
   wesen_pkg::wesen_byte_t src_p;
   logic ack_n_s;
   logic any_reset_s;

   wesen_pkg::wesen_byte_t stat_c;
   wesen_pkg::wesen_byte_t stat_e;
   wesen_pkg::wesen_byte_t stat_p;
   wesen_pkg::wesen_byte_t en_p;
   wesen_pkg::wesen_byte_t ctrl;
   wesen_pkg::wesen_byte_t next_stat_c;
   wesen_pkg::wesen_byte_t next_stat_e;
   wesen_pkg::wesen_byte_t next_stat_p;
   wesen_pkg::wesen_byte_t next_en_p;
   wesen_pkg::wesen_byte_t next_ctrl;
   logic [31:0] next_prdata;
   logic next_wake_out_n;

   wesen_pkg::wesen_sel_t sel;
   logic acc;
   logic wr;
   logic global_en;
   logic pp_active;
   logic wake_any;

   // byte address of a register index
   function automatic logic [`WESEN_ADDR_W-1:0] idx_addr(input logic [7:0] idx);
      idx_addr = {{(`WESEN_ADDR_W-10){1'b0}}, idx, 2'b00};
   endfunction

   function automatic wesen_pkg::wesen_sel_t decode(input logic [`WESEN_ADDR_W-1:0] a);
      if (a == idx_addr(`WESEN_IDX_GPIO_C)) begin
         decode = wesen_pkg::WESEN_SEL_GPIO_C;
      end else if (a == idx_addr(`WESEN_IDX_PERIPH_STS)) begin
         decode = wesen_pkg::WESEN_SEL_PERIPH_STS;
      end else if (a == idx_addr(`WESEN_IDX_PERIPH_EN)) begin
         decode = wesen_pkg::WESEN_SEL_PERIPH_EN;
      end else if (a == idx_addr(`WESEN_IDX_GPIO_E)) begin
         decode = wesen_pkg::WESEN_SEL_GPIO_E;
      end else if (a == idx_addr(`WESEN_IDX_GLOBAL_CTRL)) begin
         decode = wesen_pkg::WESEN_SEL_CTRL;
      end else begin
         decode = wesen_pkg::WESEN_SEL_NONE;
      end
   endfunction

   // sticky status with write-one-clear; set beats clear
   function automatic wesen_pkg::wesen_byte_t w1c(input wesen_pkg::wesen_byte_t cur,
                                                  input wesen_pkg::wesen_byte_t src,
                                                  input logic hit,
                                                  input wesen_pkg::wesen_byte_t wd);
      w1c = (cur & ~(hit ? wd : 8'h00)) | src;
   endfunction

   assign raw_in = {main_por, hard_reset, soft_reset, printer_ack_n,
                    two_wire_ctrl_event, watchdog_event, keyboard_ctrl_event,
                    mouse_ctrl_event, floppy_ctrl_event, serial_port1_event,
                    serial_port2_event, gpio_group_e_wake, gpio_group_c_wake};

   wesen_sync #(.WIDTH(SYNC_W)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(raw_in),
      .sync_out(sync_in)
   );

   always_comb begin
      src_c = sync_in[7:0];
      src_e = sync_in[15:8];
      ack_n_s = sync_in[23];
      any_reset_s = |sync_in[26:24];
      global_en = ctrl[`WESEN_BIT_GLOBAL_EN];
      pp_active = ctrl[`WESEN_BIT_PP_ACTIVE];
      src_p = {sync_in[22:16], (pp_active ? ack_n_s : 1'b1)};
      sel = decode(paddr);
      acc = psel && penable;
      wr = acc && pwrite;
   end

   // register next values
   always_comb begin
      next_stat_c = w1c(stat_c, src_c, wr && sel == wesen_pkg::WESEN_SEL_GPIO_C,
                        pwdata[7:0]);
      next_stat_e = w1c(stat_e, src_e, wr && sel == wesen_pkg::WESEN_SEL_GPIO_E,
                        pwdata[7:0]);
      next_stat_p = w1c(stat_p, src_p, wr && sel == wesen_pkg::WESEN_SEL_PERIPH_STS,
                        pwdata[7:0]);
      if (any_reset_s) begin
         next_stat_p[`WESEN_BIT_PP_EVENT] = 1'b1;
      end
      next_en_p = en_p;
      if (wr && sel == wesen_pkg::WESEN_SEL_PERIPH_EN) begin
         next_en_p = pwdata[7:0];
      end
      next_ctrl = ctrl;
      if (wr && sel == wesen_pkg::WESEN_SEL_CTRL) begin
         next_ctrl = pwdata[7:0] & 8'h03;
      end
   end

   // standby power-on reset is the only reset of these registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_c <= `WESEN_RST_GPIO_C;
         stat_e <= `WESEN_RST_GPIO_E;
         stat_p <= `WESEN_RST_PERIPH_STS;
         en_p <= `WESEN_RST_PERIPH_EN;
         ctrl <= `WESEN_RST_GLOBAL_CTRL;
      end else begin
         stat_c <= next_stat_c;
         stat_e <= next_stat_e;
         stat_p <= next_stat_p;
         en_p <= next_en_p;
         ctrl <= next_ctrl;
      end
   end

   // wake output and read data
   always_comb begin
      wake_any = |((en_p & peripheral_wake_status) | (gpio_group_c_enable & stat_c)
                   | (gpio_group_e_enable & stat_e));
      next_wake_out_n = !(global_en && wake_any);
      next_prdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         case (sel)
            wesen_pkg::WESEN_SEL_GPIO_C: next_prdata = {24'h00_0000, stat_c};
            wesen_pkg::WESEN_SEL_GPIO_E: next_prdata = {24'h00_0000, stat_e};
            wesen_pkg::WESEN_SEL_PERIPH_STS: next_prdata = {24'h00_0000, stat_p};
            wesen_pkg::WESEN_SEL_PERIPH_EN: next_prdata = {24'h00_0000, en_p};
            wesen_pkg::WESEN_SEL_CTRL: next_prdata = {24'h00_0000, ctrl};
            default: next_prdata = 32'h0000_0000;
         endcase
      end else if (acc) begin
         next_prdata = prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_out_n <= 1'b1;
         prdata <= 32'h0000_0000;
      end else begin
         wake_out_n <= next_wake_out_n;
         prdata <= next_prdata;
      end
   end

   assign pready = 1'b1;
   assign pslverr = acc && (sel == wesen_pkg::WESEN_SEL_NONE);

   // checks
   property p_set_c;
      @(posedge pclk) disable iff (!presetn)
      (src_c != 8'h00) |=> ((stat_c & $past(src_c)) == $past(src_c));
   endproperty
   a_set_c: assert property (p_set_c) else $error("gpio c event not latched");

   property p_set_p;
      @(posedge pclk) disable iff (!presetn)
      (src_p != 8'h00) |=> ((stat_p & $past(src_p)) == $past(src_p));
   endproperty
   a_set_p: assert property (p_set_p) else $error("peripheral event not latched");

   property p_clear_e;
      @(posedge pclk) disable iff (!presetn)
      (wr && sel == wesen_pkg::WESEN_SEL_GPIO_E && src_e == 8'h00)
         |=> ((stat_e & $past(pwdata[7:0])) == 8'h00);
   endproperty
   a_clear_e: assert property (p_clear_e) else $error("write one did not clear");

   property p_sticky_c;
      @(posedge pclk) disable iff (!presetn)
      !(wr && sel == wesen_pkg::WESEN_SEL_GPIO_C) |=> ((stat_c & $past(stat_c)) == $past(stat_c));
   endproperty
   a_sticky_c: assert property (p_sticky_c) else $error("status bit lost");

   property p_reset_bit0;
      @(posedge pclk) disable iff (!presetn)
      any_reset_s |=> stat_p[`WESEN_BIT_PP_EVENT];
   endproperty
   a_reset_bit0: assert property (p_reset_bit0) else $error("bit 0 not forced");

   property p_pp_idle;
      @(posedge pclk) disable iff (!presetn)
      !pp_active |=> stat_p[`WESEN_BIT_PP_EVENT];
   endproperty
   a_pp_idle: assert property (p_pp_idle) else $error("idle parallel not reading 1");

   property p_wake_on;
      @(posedge pclk) disable iff (!presetn)
      (global_en && (stat_c & gpio_group_c_enable) != 8'h00) |=> !wake_out_n;
   endproperty
   a_wake_on: assert property (p_wake_on) else $error("wake not driven");

   property p_wake_masked;
      @(posedge pclk) disable iff (!presetn)
      (!wake_any) |=> wake_out_n;
   endproperty
   a_wake_masked: assert property (p_wake_masked) else $error("disabled source woke");

   property p_global_off;
      @(posedge pclk) disable iff (!presetn)
      !global_en |=> wake_out_n;
   endproperty
   a_global_off: assert property (p_global_off) else $error("wake with global off");

   property p_en_write;
      @(posedge pclk) disable iff (!presetn)
      (wr && sel == wesen_pkg::WESEN_SEL_PERIPH_EN) |=> (en_p == $past(pwdata[7:0]));
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write lost");

   property p_cov_wake;
      @(posedge pclk) disable iff (!presetn)
      wake_out_n ##1 !wake_out_n;
   endproperty
   c_cov_wake: cover property (p_cov_wake);

   property p_cov_setwin;
      @(posedge pclk) disable iff (!presetn)
      wr && sel == wesen_pkg::WESEN_SEL_GPIO_C && (src_c & pwdata[7:0]) != 8'h00;
   endproperty
   c_cov_setwin: cover property (p_cov_setwin);

   property p_cov_err;
      @(posedge pclk) disable iff (!presetn)
      pslverr;
   endproperty
   c_cov_err: cover property (p_cov_err);

   property p_set_e;
      @(posedge pclk) disable iff (!presetn)
      (src_e != 8'h00) |=> ((stat_e & $past(src_e)) == $past(src_e));
   endproperty
   a_set_e: assert property (p_set_e) else $error("gpio e event not latched");

   property p_pp_follow;
      @(posedge pclk) disable iff (!presetn)
      (pp_active && ack_n_s) |=> stat_p[`WESEN_BIT_PP_EVENT];
   endproperty
   a_pp_follow: assert property (p_pp_follow) else $error("parallel not latched");

   property p_wake_on_p;
      @(posedge pclk) disable iff (!presetn)
      (global_en && (en_p & peripheral_wake_status) != 8'h00) |=> !wake_out_n;
   endproperty
   a_wake_on_p: assert property (p_wake_on_p) else $error("peripheral wake missed");

   property p_en_hold;
      @(posedge pclk) disable iff (!presetn)
      !(wr && sel == wesen_pkg::WESEN_SEL_PERIPH_EN) |=> (en_p == $past(en_p));
   endproperty
   a_en_hold: assert property (p_en_hold) else $error("enable changed");

   property p_cov_reset;
      @(posedge pclk) disable iff (!presetn)
      any_reset_s ##1 stat_p[`WESEN_BIT_PP_EVENT];
   endproperty
   c_cov_reset: cover property (p_cov_reset);
endmodule
